/* bench/bus_memory_model.sv */
// Memory and peripherals model answering the sequencer's bus cycles
`timescale 1ns/1ns
module bus_memory_model (
   input  wire logic                   ref_clk_i,  // Processor clock
   input  wire sequencer_pkg::bus_type bus_i,      // Bus cycle from the core
   output logic [7:0]                  data_o      // Read data to the core
);
   import sequencer_pkg::*;
   logic [7:0] mem [0:65535];  // Whole address space
   logic [7:0] last = 8'h00;   // Last byte handed to the core
   ////////////////////////////////////////////////////////////////////////////
   // Pattern fill, so that no read ever returns unknowns
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end
   // Bench places program bytes here
   task automatic load(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask : load
   // Writes land at the edge that ends the cycle
   always @(posedge ref_clk_i) begin
      if (!bus_i.rw) begin
         mem[bus_i.addr] <= bus_i.wdata;
      end else begin
         last <= mem[bus_i.addr];
      end
   end
   // A write cycle shows the inverse of the last byte read, never a stale copy
   assign data_o = bus_i.rw ? mem[bus_i.addr] : ~last;
endmodule : bus_memory_model

/* bench/test_branch_wait_cycle_sequencer.sv */
// Self-checking bench of the branch, wait and test-opcode sequencer
`timescale 1ns/1ns
module test_branch_wait_cycle_sequencer;
   import sequencer_pkg::*;
   // Opcode, length, cycles of plain instructions
   localparam logic [7:0][15:0] TBL = {16'h0112, 16'h3D1A, 16'h8334, 16'h8C34,
                                       16'h8E33, 16'hC334, 16'hCC33, 16'hCE33};
   logic          ref_clk_i = 1'h0;       // Processor clock
   logic          srst_i = 1'h1;          // Reset, high from time zero
   logic [7:0]    data_i;                 // Read data from the memory model
   core_regs_type regs_i = '0;            // Register file seen by the core
   logic          branch_taken_i = 1'h0;  // Branch condition
   logic          resume_i = 1'h0;        // Ends the wait state
   bus_type       bus_o;                  // Bus cycle under test
   logic [15:0]   pc_o;                   // Opcode address
   core_regs_type nregs;                  // Registers of the next scenario
   logic [26:0]   exp_q[$];               // Model cycles: addr, rw, wdata, fetch, resume
   logic [15:0]   pc;                     // Model program counter
   logic [31:0]   seed = 32'hC26860AA;    // Random generator state
   int            n_fail = 0;             // Mismatches
   int            n_compared = 0;         // Comparisons
   int            cyc = 0;                // Cycles run
   int            rst_len = 12;           // First reset is the long one
   logic [31:0]   r;                      // Scratch random word
   logic          tk;                     // Branch condition of a scenario
   ////////////////////////////////////////////////////////////////////////////
   branch_wait_cycle_sequencer uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .data_i(data_i), .regs_i(regs_i),
      .branch_taken_i(branch_taken_i), .resume_i(resume_i), .bus_o(bus_o), .pc_o(pc_o));
   bus_memory_model mem_i (.ref_clk_i(ref_clk_i), .bus_i(bus_o), .data_o(data_i));
   // Clock, and a ceiling far above the few hundred cycles needed
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Shift register generator, fixed seed
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rd(input logic [15:0] a, input logic f, input logic res = 1'h0);
      exp_q.push_back({a, 1'h1, 8'h00, f, res});
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      exp_q.push_back({a, 1'h0, d, 1'h0, 1'h0});
   endtask : wr
   // New registers, stack kept clear of the program
   task automatic start();
      logic [63:0] w;
      w = {rnd(), rnd()};
      nregs = w[55:0];
      nregs.sp = 16'h4000 | {4'h0, nregs.sp[11:0]};
      pc = 16'h0000;
      exp_q.delete();
   endtask : start
   // Offset never lands the target on the branch itself
   task automatic br(input logic [7:0] op, input logic t);
      logic [7:0] off;
      r = rnd();
      off = r[7] ? {2'h2, r[5:0]} : {1'h0, r[6:0] | 7'h04};
      mem_i.load(pc, op);
      mem_i.load(pc + 16'h0001, off);
      rd(pc, 1'h1);
      rd(pc + 16'h0001, 1'h0);
      rd(16'hFFFF, 1'h0);
      pc = pc + 16'h0002 + (t ? {{8{off[7]}}, off} : 16'h0000);
   endtask : br
   // Call lands on a one-byte opcode that is already fetched
   task automatic sub();
      logic [15:0] ret;
      ret = pc + 16'h0002;
      br(8'h8D, 1'h1);
      mem_i.load(pc, 8'h01);
      rd(pc, 1'h0);
      wr(nregs.sp, ret[7:0]);
      wr(nregs.sp - 16'h0001, ret[15:8]);
      rd(pc + 16'h0001, 1'h0);
      pc = pc + 16'h0001;
   endtask : sub
   task automatic wt(input int n);
      logic [15:0] ret;
      logic [7:0]  st[7];
      ret = pc + 16'h0001;
      st = '{ret[7:0], ret[15:8], nregs.x[7:0], nregs.x[15:8], nregs.a, nregs.b, nregs.ccr};
      mem_i.load(pc, 8'h3E);
      rd(pc, 1'h1);
      rd(ret, 1'h0);
      for (int k = 0; k < 7; k++) begin
         wr(nregs.sp - 16'(k), st[k]);
      end
      for (int k = 1; k <= n; k++) begin
         rd(nregs.sp - 16'h0007, 1'h0, k == n);
      end
      pc = ret;
   endtask : wt
   task automatic oth(input logic [7:0] op, input int len, input int cyc_n);
      mem_i.load(pc, op);
      rd(pc, 1'h1);
      rd(pc + 16'h0001, 1'h0);
      repeat (cyc_n - 2) begin
         rd(16'hFFFF, 1'h0);
      end
      pc = pc + 16'(len);
   endtask : oth
   // Reset, then compare every bus cycle against the model queue
   task automatic go(input logic t);
      logic [26:0] ex;
      @(posedge ref_clk_i);
      srst_i <= 1'h1;
      regs_i <= nregs;
      branch_taken_i <= t;
      repeat (rst_len) @(posedge ref_clk_i);
      #1;
      check("pc_o", pc_o, 16'h0000);
      rst_len = 2;
      @(posedge ref_clk_i);
      srst_i <= 1'h0;
      while (exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         resume_i <= ex[0];
         #1;
         check("addr", bus_o.addr, ex[26:11]);
         check("rw", 16'(bus_o.rw), 16'(ex[10]));
         if (!ex[10]) check("wdata", 16'(bus_o.wdata), 16'(ex[9:2]));
         check("data_oe_n", 16'(bus_o.data_oe_n), 16'(ex[10]));
         check("addr_oe_n", 16'(bus_o.addr_oe_n), 16'h0000);
         check("fetch", 16'(bus_o.fetch), 16'(ex[1]));
         if (ex[1]) check("pc_o", pc_o, ex[26:11]);
         @(posedge ref_clk_i);
      end
   endtask : go
   task automatic complete_run();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk_i);
      for (int i = 0; i < 16; i++) begin
         start();
         r = rnd();
         tk = (i == 0) | ((i != 1) & r[0]);
         br(8'h20 + 8'(i), tk);
         rd(pc, 1'h1);
         go(tk);
      end
      for (int i = 0; i < 4; i++) begin
         start();
         oth(8'h01, 1, 2);
         sub();
         rd(pc, 1'h1);
         go(1'h0);
      end
      for (int i = 0; i < 6; i++) begin
         start();
         br(8'h20, 1'h1);
         r = rnd();
         wt(1 + int'(r[2:0]));
         rd(pc, 1'h1);
         go(1'h1);
      end
      start();
      for (int i = 0; i < 8; i++) begin
         oth(TBL[i][15:8], int'(TBL[i][7:4]), int'(TBL[i][3:0]));
      end
      rd(pc, 1'h1);
      go(1'h0);
      for (int i = 0; i < 2; i++) begin
         start();
         oth(8'h01, 1, 2);
         mem_i.load(pc, i == 0 ? 8'h4E : 8'h5E);
         for (int k = 0; k < 24; k++) begin
            rd(pc + 16'(k), k == 0);
         end
         go(1'h0);
      end
      // Only a reset leaves the endless opcode
      start();
      rd(pc, 1'h1);
      go(1'h0);
      complete_run();
   end
endmodule : test_branch_wait_cycle_sequencer

/* src/branch_wait_cycle_sequencer.sv */
// Bus cycle sequencer for branches, subroutine calls, wait state and test opcodes
//
// Overview of operation
// - Wait state reads stack pointer minus seven repeatedly
// - Wait instruction never floats the address or rw lines
// - Branches: opcode, offset, dummy read of FFFF
// - Subroutine call: branch cycles, then target read
// - Cycles five, six push return low, high
// - Thirty-six undefined opcodes, results unpredictable
// - Test opcodes increment address until reset
// - Test opcodes are one byte, never finish
// - Listed immediate forms are three bytes long
// - Cycles equal column base plus increment, base minus three for 6E, 7E
// - Wait takes nine cycles, pushing seven bytes
`timescale 1ns/1ns
module branch_wait_cycle_sequencer (
   input  wire logic                        ref_clk_i,       // Processor clock
   input  wire logic                        srst_i,          // Synchronous reset, active high
   input  wire logic [7:0]                  data_i,          // Read data for the current cycle
   input  wire sequencer_pkg::core_regs_type regs_i,         // Register file contents
   input  wire logic                        branch_taken_i,  // Branch condition is true
   input  wire logic                        resume_i,        // Interrupt ends the wait state
   output sequencer_pkg::bus_type           bus_o,           // Registered bus cycle
   output logic [15:0]                      pc_o             // Current opcode address
);
   import sequencer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   seq_state_type state, next_state;        // Sequencer state
   logic [15:0]   pc, next_pc;              // Opcode address of this instruction
   logic [7:0]    opcode, next_opcode;      // Opcode under execution
   logic [7:0]    saved_op, next_saved_op;  // Opcode prefetched at call target
   logic [15:0]   target, next_target;      // Branch destination
   logic [15:0]   sp_base, next_sp_base;    // Stack pointer seen at push start
   logic [3:0]    cnt, next_cnt;            // Push index or extra cycles left
   bus_type       bus, next_bus;            // Bus cycle on the pins
   decode_type    dec;                      // Attributes of the held opcode
   logic [3:0]    push_idx;                 // Index of next push byte
   logic [15:0]   ret_addr;                 // Return address being stacked

   ////////////////////////////////////////////////////////////////////////////
   // Decoder on the held opcode
   opcode_length_decoder decoder (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .opcode_i  (opcode),
      .dec_o     (dec)
   );

   // Byte stacked at a given push index
   function automatic logic [7:0] push_byte(input logic [3:0] idx, input logic [15:0] ret,
                                            input core_regs_type r);
      case (idx)
         4'h0    : push_byte = ret[7:0];
         4'h1    : push_byte = ret[15:8];
         4'h2    : push_byte = r.x[7:0];
         4'h3    : push_byte = r.x[15:8];
         4'h4    : push_byte = r.a;
         4'h5    : push_byte = r.b;
         default : push_byte = r.ccr;
      endcase
   endfunction : push_byte

   ////////////////////////////////////////////////////////////////////////////
   // Next-state and next-bus logic
   always_comb begin
      next_state    = state;
      next_pc       = pc;
      next_opcode   = opcode;
      next_saved_op = saved_op;
      next_target   = target;
      next_sp_base  = sp_base;
      next_cnt      = cnt;
      push_idx      = cnt + 4'h1;
      ret_addr      = (opcode == OP_WAIT_INTR) ? pc + 16'h0001 : pc + 16'h0002;
      // Default cycle is a read with address lines driven
      next_bus           = bus;
      next_bus.rw        = 1'b1;
      next_bus.wdata     = 8'h00;
      next_bus.data_oe_n = 1'b1;
      next_bus.addr_oe_n = 1'b0;
      next_bus.fetch     = 1'b0;
      case (state)
         ST_FETCH: begin
            next_opcode   = data_i;
            next_bus.addr = pc + 16'h0001;
            if ((data_i == OP_TEST_A) || (data_i == OP_TEST_B)) begin
               next_state = ST_TEST;
            end else begin
               next_state = ST_OPER;
            end
         end
         ST_OPER: begin
            // Second byte is the branch offset for the relative family
            next_target = pc + 16'h0002 + {{8{data_i[7]}}, data_i};
            if (dec.wait_instr) begin
               next_sp_base       = regs_i.sp;
               next_cnt           = 4'h0;
               next_state         = ST_PUSH;
               next_bus.addr      = regs_i.sp;
               next_bus.rw        = 1'b0;
               next_bus.data_oe_n = 1'b0;
               next_bus.wdata     = push_byte(4'h0, ret_addr, regs_i);
            end else if (dec.relative) begin
               next_state    = ST_DUMMY;
               next_bus.addr = DUMMY_ADDR;
            end else if (dec.cycles > 5'h02) begin
               // Inner cycles of other instructions shown as dummy reads
               next_cnt      = 4'(dec.cycles - 5'h03);
               next_state    = ST_EXTRA;
               next_bus.addr = DUMMY_ADDR;
            end else begin
               next_pc        = pc + {14'h0000, dec.len};
               next_state     = ST_FETCH;
               next_bus.addr  = pc + {14'h0000, dec.len};
               next_bus.fetch = 1'b1;
            end
         end
         ST_DUMMY: begin
            if (dec.subroutine) begin
               next_state    = ST_TARGET;
               next_bus.addr = target;
            end else begin
               // Taken or not, the branch costs the same three cycles
               next_pc        = branch_taken_i ? target : pc + 16'h0002;
               next_state     = ST_FETCH;
               next_bus.addr  = branch_taken_i ? target : pc + 16'h0002;
               next_bus.fetch = 1'b1;
            end
         end
         ST_TARGET: begin
            // Opcode at the target is kept so it need not be fetched again
            next_saved_op      = data_i;
            next_sp_base       = regs_i.sp;
            next_cnt           = 4'h0;
            next_state         = ST_PUSH;
            next_bus.addr      = regs_i.sp;
            next_bus.rw        = 1'b0;
            next_bus.data_oe_n = 1'b0;
            next_bus.wdata     = push_byte(4'h0, ret_addr, regs_i);
         end
         ST_PUSH: begin
            if (dec.wait_instr && (cnt == WAIT_PUSH_LAST)) begin
               next_state    = ST_WAIT;
               next_bus.addr = sp_base - WAIT_SP_OFFSET;
            end else if (!dec.wait_instr && (cnt == SUB_PUSH_LAST)) begin
               // Resume at the operand cycle of the prefetched opcode
               next_pc       = target;
               next_opcode   = saved_op;
               next_state    = ST_OPER;
               next_bus.addr = target + 16'h0001;
            end else begin
               next_cnt           = push_idx;
               next_bus.addr      = sp_base - {12'h000, push_idx};
               next_bus.rw        = 1'b0;
               next_bus.data_oe_n = 1'b0;
               next_bus.wdata     = push_byte(push_idx, ret_addr, regs_i);
            end
         end
         ST_WAIT: begin
            // Idle reads keep address and rw driven; the data bus is not driven here
            if (resume_i) begin
               next_pc        = pc + 16'h0001;
               next_state     = ST_FETCH;
               next_bus.addr  = pc + 16'h0001;
               next_bus.fetch = 1'b1;
            end else begin
               next_bus.addr = sp_base - WAIT_SP_OFFSET;
            end
         end
         ST_TEST: begin
            // Only reset leaves this state
            next_bus.addr = bus.addr + 16'h0001;
         end
         ST_EXTRA: begin
            if (cnt == 4'h0) begin
               next_pc        = pc + {14'h0000, dec.len};
               next_state     = ST_FETCH;
               next_bus.addr  = pc + {14'h0000, dec.len};
               next_bus.fetch = 1'b1;
            end else begin
               next_cnt      = cnt - 4'h1;
               next_bus.addr = DUMMY_ADDR;
            end
         end
         default: begin
            next_state = ST_FETCH;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state     <= ST_FETCH;
         pc        <= RESET_PC;
         opcode    <= 8'h00;
         saved_op  <= 8'h00;
         target    <= RESET_PC;
         sp_base   <= 16'h0000;
         cnt       <= 4'h0;
         bus.addr      <= RESET_PC;
         bus.rw        <= 1'b1;
         bus.wdata     <= 8'h00;
         bus.data_oe_n <= 1'b1;
         bus.addr_oe_n <= 1'b0;
         bus.fetch     <= 1'b1;
      end else begin
         state     <= next_state;
         pc        <= next_pc;
         opcode    <= next_opcode;
         saved_op  <= next_saved_op;
         target    <= next_target;
         sp_base   <= next_sp_base;
         cnt       <= next_cnt;
         bus       <= next_bus;
      end
   end

   assign bus_o = bus;
   assign pc_o  = pc;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_dummy_then_fetch;
      (bus.addr == DUMMY_ADDR) && bus.rw ##1 bus.fetch;
   endsequence
   sequence s_two_pushes;
      (!bus.rw && (bus.addr == sp_base)) ##1 (!bus.rw && (bus.addr == sp_base - 16'h0001));
   endsequence

   a_wait_idle_addr: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_WAIT) |-> (bus.addr == sp_base - 16'h0007) && bus.rw)
      else $error("wait idle address wrong");
   // The first wait cycle follows the last push, so stability is checked from one wait cycle to the next
   a_ports_driven: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_WAIT) |-> (!bus.addr_oe_n && bus.data_oe_n) ##1 ((state != ST_WAIT) || $stable(bus.addr)))
      else $error("port floated during wait");
   a_branch_three: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_OPER && dec.relative && !dec.subroutine) |=> s_dummy_then_fetch)
      else $error("branch cycle sequence wrong");
   a_call_target: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_DUMMY && dec.subroutine) |=> bus.rw && (bus.addr == $past(target)))
      else $error("call target read wrong");
   a_call_pushes: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_TARGET) |=> s_two_pushes ##1 (state == ST_OPER))
      else $error("return address push wrong");
   a_test_counts: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_TEST) |=> (state == ST_TEST) && (bus.addr == $past(bus.addr) + 16'h0001))
      else $error("test opcode address not counting");
   a_wait_nine: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (state == ST_OPER && dec.wait_instr) |=> (!bus.rw)[*7] ##1 (state == ST_WAIT))
      else $error("wait push sequence wrong");

endmodule : branch_wait_cycle_sequencer

/* src/opcode_length_decoder.sv */
// Opcode decoder giving length, cycle count and class of each opcode
`timescale 1ns/1ns
module opcode_length_decoder (
   input  wire logic                      ref_clk_i,  // Used by the checks only
   input  wire logic                      srst_i,     // Used by the checks only
   input  wire logic [7:0]                opcode_i,   // Opcode under decode
   output sequencer_pkg::decode_type      dec_o       // Decoded attributes
);
   import sequencer_pkg::*;

   logic [3:0] inc;     // Per-instruction cycle increment
   logic       shorten; // Jump columns subtract instead

   ////////////////////////////////////////////////////////////////////////////
   // Increment table; column base plus this gives the count
   always_comb begin
      inc     = 4'h0;
      shorten = 1'b0;
      case (opcode_i)
         8'h04, 8'h05, 8'h08, 8'h09, 8'h32, 8'h33, 8'h3C : inc = 4'h1;
         8'h38, 8'h39, 8'h83, 8'h93, 8'hA3, 8'hB3,
         8'hC3, 8'hD3, 8'hE3, 8'hF3, 8'h8C, 8'h9C,
         8'hAC, 8'hBC, 8'h9D, 8'hAD, 8'hBD           : inc = 4'h2;
         8'h3B, OP_MULTIPLY                          : inc = 4'h7;
         OP_WAIT_INTR                                : inc = 4'h6;
         8'h3F                                       : inc = 4'h9;
         OP_SUBROUTINE                               : inc = 4'h4;  // Six in total
         8'hCC, 8'hDC, 8'hEC, 8'hFC, 8'hDD, 8'hED,
         8'hFD, 8'h8E, 8'h9E, 8'hAE, 8'hBE, 8'hCE,
         8'hDE, 8'hEE, 8'hFE, 8'h9F, 8'hAF, 8'hBF,
         8'hDF, 8'hEF, 8'hFF                         : inc = 4'h1;
         8'h6E, 8'h7E                                : shorten = 1'b1;
         default                                     : inc = 4'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Length, count and class flags
   always_comb begin
      dec_o.len    = COL_LEN[opcode_i[7:4]];
      dec_o.cycles = {1'b0, COL_CYC[opcode_i[7:4]]} + {1'b0, inc};
      if (shorten) begin
         dec_o.cycles = {1'b0, COL_CYC[opcode_i[7:4]]} - JUMP_REDUCTION;
      end
      case (opcode_i)
         8'h83, 8'h8C, 8'h8E, 8'hC3, 8'hCC, 8'hCE,
         8'h8F, 8'hCD, 8'hCF : dec_o.len = LONG_LEN;
         default             : ;
      endcase
      // Undefined set, results are left unpredictable
      case (opcode_i)
         8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h1A,
         8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h41, 8'h42, 8'h45, 8'h4B, 8'h4E,
         8'h51, 8'h52, 8'h55, 8'h5B, 8'h5E, 8'h61, 8'h62, 8'h65, 8'h6B,
         8'h71, 8'h72, 8'h75, 8'h7B, 8'h87, 8'h8F, 8'hC7, 8'hCD,
         8'hCF    : dec_o.undefined = 1'b1;
         default  : dec_o.undefined = 1'b0;
      endcase
      dec_o.endless    = (opcode_i == OP_TEST_A) || (opcode_i == OP_TEST_B);
      if (dec_o.endless) begin
         dec_o.len = 2'h1;
      end
      dec_o.subroutine = (opcode_i == OP_SUBROUTINE);
      dec_o.relative   = (opcode_i[7:4] == REL_ROW) || dec_o.subroutine;
      dec_o.wait_instr = (opcode_i == OP_WAIT_INTR);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the decode table
   a_test_one_byte: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      ((opcode_i == OP_TEST_A) || (opcode_i == OP_TEST_B)) |-> (dec_o.len == 2'h1) && dec_o.endless)
      else $error("test opcode not one byte and endless");
   a_three_byte_forms: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (opcode_i inside {8'h83, 8'h8C, 8'h8E, 8'hC3, 8'hCC, 8'hCE, 8'h8F, 8'hCD, 8'hCF})
      |-> (dec_o.len == 2'h3))
      else $error("immediate long form not three bytes");
   a_multiply_count: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (opcode_i == OP_MULTIPLY) |-> (dec_o.cycles == 5'h0A))
      else $error("multiply count not ten");
   a_undefined_mark: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (opcode_i inside {8'h4E, 8'h87, 8'hCD}) |-> dec_o.undefined)
      else $error("undefined opcode not flagged");

endmodule : opcode_length_decoder

/* src/sequencer_pkg.sv */
// Shared constants, types and state encoding of the instruction sequencer
package sequencer_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Addresses and offsets
   localparam logic [15:0] RESET_PC        = 16'h0000;  // First opcode address after reset
   localparam logic [15:0] DUMMY_ADDR      = 16'hFFFF;  // Address of every dummy read
   localparam logic [15:0] WAIT_SP_OFFSET  = 16'h0007;  // Idle read sits this far below SP
   localparam logic [3:0]  SUB_PUSH_LAST   = 4'h1;      // Index of last subroutine push
   localparam logic [3:0]  WAIT_PUSH_LAST  = 4'h6;      // Index of last wait push

   ////////////////////////////////////////////////////////////////////////////
   // Opcodes the sequencer treats specially
   localparam logic [7:0] OP_WAIT_INTR    = 8'h3E;  // Wait-for-interrupt
   localparam logic [7:0] OP_SUBROUTINE   = 8'h8D;  // Branch-to-subroutine
   localparam logic [7:0] OP_MULTIPLY     = 8'h3D;  // Multiply
   localparam logic [7:0] OP_TEST_A       = 8'h4E;  // Endless test opcode
   localparam logic [7:0] OP_TEST_B       = 8'h5E;  // Endless test opcode
   localparam logic [3:0] REL_ROW         = 4'h2;   // High nibble of relative branches

   ////////////////////////////////////////////////////////////////////////////
   // Per-column base bytes and cycles, index is the opcode high nibble
   localparam logic [15:0][1:0] COL_LEN = {2'h3, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2,
                                           2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
   localparam logic [15:0][3:0] COL_CYC = {4'h4, 4'h4, 4'h3, 4'h2, 4'h4, 4'h4, 4'h3, 4'h2,
                                           4'h6, 4'h6, 4'h2, 4'h2, 4'h3, 4'h3, 4'h2, 4'h2};
   localparam logic [1:0] LONG_LEN        = 2'h3;   // Length of three-byte forms
   localparam logic [4:0] JUMP_REDUCTION  = 5'h03;  // Jump columns run three short

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer states, Gray along fetch, operand, dummy, target, push
   typedef enum logic [2:0] {
      ST_FETCH  = 3'b000,
      ST_OPER   = 3'b001,
      ST_DUMMY  = 3'b011,
      ST_TARGET = 3'b010,
      ST_PUSH   = 3'b110,
      ST_WAIT   = 3'b111,
      ST_TEST   = 3'b101,
      ST_EXTRA  = 3'b100
   } seq_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [15:0] addr;       // Address bus
      logic        rw;         // High = read, low = write
      logic [7:0]  wdata;      // Write data
      logic        data_oe_n;  // Low while the data bus is driven
      logic        addr_oe_n;  // Low while address and rw are driven
      logic        fetch;      // High during an opcode fetch cycle
   } bus_type;

   typedef struct packed {
      logic [15:0] sp;   // Stack pointer
      logic [15:0] x;    // Index register
      logic [7:0]  a;    // Accumulator A
      logic [7:0]  b;    // Accumulator B
      logic [7:0]  ccr;  // Condition codes
   } core_regs_type;

   typedef struct packed {
      logic [1:0] len;         // Instruction bytes
      logic [4:0] cycles;      // Total bus cycles
      logic       undefined;   // One of the undefined opcodes
      logic       endless;     // Never completes on its own
      logic       relative;    // Relative branch family
      logic       subroutine;  // Branch-to-subroutine
      logic       wait_instr;  // Wait-for-interrupt
   } decode_type;

endpackage : sequencer_pkg
